// ---- rtl/synth_cfg_pkg.sv ----
// Constants, field layouts and types shared by the synthesizer config logic.
package synth_cfg_pkg;

  // Clock rate and serial word size.
  localparam int MCLK_MHZ = 40;
  localparam int WORD_W = 32;

  // Register select codes carried in the low three bits of each word.
  localparam logic [2:0] SEL_INT_FRAC = 3'h0;
  localparam logic [2:0] SEL_PHASE_DENOM = 3'h1;
  localparam logic [2:0] SEL_CONTROL = 3'h2;
  localparam logic [2:0] SEL_BOOST_CLKDIV = 3'h3;
  localparam logic [2:0] SEL_OUT_STAGE = 3'h4;

  // Noise mode encodings; only low spur turns dither on.
  localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
  localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;

  // Clock divider mode encodings.
  localparam logic [1:0] CLKDIV_OFF = 2'h0;
  localparam logic [1:0] CLKDIV_RESYNC = 2'h2;

  // Internal signals that the multiplexer can place on its pin.
  localparam logic [2:0] MUX_LOW = 3'h0;
  localparam logic [2:0] MUX_HIGH = 3'h1;
  localparam logic [2:0] MUX_REF_DIV = 3'h3;
  localparam logic [2:0] MUX_FEEDBACK = 3'h4;
  localparam logic [2:0] MUX_LOCK = 3'h6;

  // Lock detector cycle counts and comparison windows.
  localparam int LOCK_COUNT_LONG = 40;
  localparam int LOCK_COUNT_SHORT = 5;
  localparam int WIN_LONG_NS = 10;
  localparam int WIN_SHORT_NS = 6;
  localparam int WIN_LONG_RAW = (WIN_LONG_NS * MCLK_MHZ) / 1000;
  localparam int WIN_SHORT_RAW = (WIN_SHORT_NS * MCLK_MHZ) / 1000;
  localparam int WIN_LONG_CYC = (WIN_LONG_RAW < 1) ? 1 : WIN_LONG_RAW;
  localparam int WIN_SHORT_CYC = (WIN_SHORT_RAW < 1) ? 1 : WIN_SHORT_RAW;

  // Reset value of every stored word.
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  // Phase and denominator word.
  typedef struct packed {
    logic [4:0] rsvd;
    logic [11:0] phase_word;
    logic [11:0] fractional_denominator;
    logic [2:0] register_select_code;
  } phase_word_t;

  // Control word.
  typedef struct packed {
    logic rsvd_hi;
    logic [1:0] noise_mode;
    logic [2:0] internal_signal_select;
    logic ref_doubler;
    logic reference_halver;
    logic [9:0] ref_ratio;
    logic double_buffer;
    logic rsvd_mid;
    logic [2:0] cp_current;
    logic lock_cycle_count_select;
    logic lock_window_select;
    logic rsvd_lo;
    logic software_sleep;
    logic cp_three_state;
    logic counter_reset;
    logic [2:0] register_select_code;
  } control_word_t;

  // Boost and clock divider word.
  typedef struct packed {
    logic [12:0] rsvd_hi;
    logic boost_enable;
    logic rsvd_mid;
    logic [1:0] clkdiv_mode;
    logic [11:0] clkdiv_value;
    logic [2:0] register_select_code;
  } boost_word_t;

  // Output stage word, of which only the divider select is kept.
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic [2:0] out_div_select;
    logic [16:0] rsvd_lo;
    logic [2:0] register_select_code;
  } out_stage_word_t;

endpackage

// ---- rtl/ref_path.sv ----
// Reference edge selection, reference divider counter and halver.
`timescale 1ns/1ps
`default_nettype none
module ref_path #(
  parameter int RATIO_W = 10
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ref_i,
  input wire logic doubler_i,
  input wire logic halver_i,
  input wire logic hold_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  output logic pfd_ref_o
);
  logic ref_q;
  logic [RATIO_W-1:0] cnt_q;
  logic tog_q;
  logic fall;
  logic active;
  logic wrap;
  logic [RATIO_W-1:0] last;

  // Falling edge only, or both edges when the doubler is on.
  assign fall = ref_q & ~ref_i;
  assign active = doubler_i ? (ref_q ^ ref_i) : fall;
  assign last = (ratio_i == '0) ? '0 : ratio_i - 1'b1;
  assign wrap = active && (cnt_q == last);

  // Previous reference level for edge detection.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_i;
    end
  end

  // Divider counter and halver toggle, both held in their load state.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
      pfd_ref_o <= 1'b0;
    end else if (hold_i) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
      pfd_ref_o <= 1'b0;
    end else begin
      if (active) begin
        cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      end
      if (wrap) begin
        tog_q <= ~tog_q;
      end
      pfd_ref_o <= wrap && (!halver_i || !tog_q);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/lock_detect.sv ----
// Digital lock detector counting consecutive in-window comparisons.
`timescale 1ns/1ps
`default_nettype none
module lock_detect #(
  parameter int AGE_W = 8,
  parameter int CNT_W = 6
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clear_i,
  input wire logic ref_evt_i,
  input wire logic fb_evt_i,
  input wire logic [AGE_W-1:0] win_i,
  input wire logic [CNT_W-1:0] need_i,
  output logic lock_o
);
  logic [AGE_W-1:0] ref_age_q;
  logic [AGE_W-1:0] fb_age_q;
  logic paired_q;
  logic [CNT_W-1:0] good_q;
  logic pair;
  logic miss;

  // A pair is a feedback edge within the window of a reference edge.
  assign pair = (ref_evt_i && (fb_evt_i || fb_age_q < win_i)) ||
                (fb_evt_i && !paired_q && ref_age_q < win_i);
  assign miss = !paired_q && !pair && (ref_age_q == win_i);

  // Ages since the last edge of each input, saturating.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_age_q <= '1;
      fb_age_q <= '1;
      paired_q <= 1'b1;
    end else if (clear_i) begin
      ref_age_q <= '1;
      fb_age_q <= '1;
      paired_q <= 1'b1;
    end else begin
      ref_age_q <= ref_evt_i ? '0 :
                   (ref_age_q == '1) ? ref_age_q : ref_age_q + 1'b1;
      fb_age_q <= fb_evt_i ? '0 :
                  (fb_age_q == '1) ? fb_age_q : fb_age_q + 1'b1;
      paired_q <= pair ? 1'b1 : (ref_evt_i ? 1'b0 : paired_q);
    end
  end

  // Consecutive good comparisons; lock only after the chosen count.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      good_q <= '0;
      lock_o <= 1'b0;
    end else if (clear_i || miss) begin
      good_q <= '0;
      lock_o <= 1'b0;
    end else if (pair) begin
      good_q <= (good_q == need_i) ? good_q : good_q + 1'b1;
      lock_o <= (good_q + 1'b1 >= need_i);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/synth_config_registers.sv ----
// Serial-loaded configuration registers with reference and lock logic.
//
// How it works
// - Select code 010 loads control, 011 boost/divider, 100 output stage.
// - Denominator comes from bits 14..3 of the phase/denominator word.
// - Noise mode bits 30..29: low spur dithers, low noise does not.
// - Bits 28..26 choose the internal signal driven onto the mux pin.
// - Bit 25 doubles the reference ahead of the reference divider.
// - Doubler off: falling edge only; on: both edges are active.
// - Bit 24 adds a divide-by-two toggle after the reference divider.
// - Reference divider ratio from bits 23..14; host uses 1 to 1023.
// - Bit 13 enables double buffering of output divider select.
// - Bits 11..9 set charge pump current, matching the loop filter.
// - Lock detector counts 40 cycles with bit 8 clear, 5 when set.
// - Window 10 ns or 6 ns by bit 7, both one MCLK cycle at 40 MHz; lock after consecutive hits.
// - Bit 5 sleeps the synthesizer; stored words are kept throughout.
// - Sleep loads counters, tristates pump, clears lock, disables outputs.
// - Bit 4 forces the charge pump output to high impedance.
// - Bit 3 holds feedback and reference counters in reset.
// - Bit 18 boost: extra pump cell runs until near lock.
// - Divider mode 10 enables phase resync, 00 turns divider off.
// - Bits 14..3 of boost word give the resync timeout count.
// - Select code 000 is integer/fraction, 001 phase/denominator.
// - Buffered divider select takes effect on next integer/fraction write.
`timescale 1ns/1ps
`default_nettype none
module synth_config_registers #(
  parameter int WORD_W = synth_cfg_pkg::WORD_W,
  parameter int AGE_W = 8,
  parameter int CNT_W = 6
) (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_LE_I,
  input wire logic REF_CLK_I,
  input wire logic FB_PULSE_I,
  output logic PFD_REF_O,
  output logic LOCK_DETECT_O,
  output logic MUX_OUT_O,
  output logic DITHER_EN_O,
  output logic [2:0] CP_CURRENT_O,
  output logic CP_TRISTATE_O,
  output logic BOOST_CELL_O,
  output logic SLEEP_O,
  output logic OUT_BUF_EN_O,
  output logic COUNTER_HOLD_O,
  output logic [11:0] FRAC_DENOM_O,
  output logic [11:0] PHASE_WORD_O,
  output logic [2:0] OUT_DIV_SEL_O,
  output logic RESYNC_EN_O,
  output logic RESYNC_FIRE_O
);

  // Serial capture state.
  logic sclk_q;
  logic le_q;
  logic [WORD_W-1:0] shift_q;
  logic sclk_rise;
  logic le_rise;
  logic [2:0] sel;

  // Stored configuration words.
  synth_cfg_pkg::phase_word_t phase_q;
  synth_cfg_pkg::control_word_t ctrl_q;
  synth_cfg_pkg::boost_word_t boost_q;
  logic [2:0] div_pending_q;
  synth_cfg_pkg::out_stage_word_t out_word;

  // Derived write strobes.
  logic wr_int_frac;
  logic wr_phase;
  logic wr_ctrl;
  logic wr_boost;
  logic wr_out;

  // Internal datapath signals.
  logic hold;
  logic pfd_ref;
  logic lock;
  logic fb_q;
  logic fb_evt;
  logic [AGE_W-1:0] win;
  logic [CNT_W-1:0] need;
  logic [11:0] resync_cnt_q;
  logic resync_armed_q;
  logic mux_d;

  // Edges of the serial clock and load strobe; pins are synchronous.
  assign sclk_rise = SER_CLK_I & ~sclk_q;
  assign le_rise = SER_LE_I & ~le_q;
  assign sel = shift_q[2:0];

  // The shifted word seen through the output stage layout.
  assign out_word = shift_q;

  // Address decode of a completed word.
  assign wr_int_frac = le_rise && sel == synth_cfg_pkg::SEL_INT_FRAC;
  assign wr_phase = le_rise && sel == synth_cfg_pkg::SEL_PHASE_DENOM;
  assign wr_ctrl = le_rise && sel == synth_cfg_pkg::SEL_CONTROL;
  assign wr_boost = le_rise && sel == synth_cfg_pkg::SEL_BOOST_CLKDIV;
  assign wr_out = le_rise && sel == synth_cfg_pkg::SEL_OUT_STAGE;

  // Sleep and counter reset both keep the counters in their load state.
  assign hold = ctrl_q.software_sleep | ctrl_q.counter_reset;

  // Lock window and required count follow the control bits.
  assign win = ctrl_q.lock_window_select ?
               AGE_W'(synth_cfg_pkg::WIN_SHORT_CYC) :
               AGE_W'(synth_cfg_pkg::WIN_LONG_CYC);
  assign need = ctrl_q.lock_cycle_count_select ?
                CNT_W'(synth_cfg_pkg::LOCK_COUNT_SHORT) :
                CNT_W'(synth_cfg_pkg::LOCK_COUNT_LONG);

  // Feedback pulse edge.
  assign fb_evt = FB_PULSE_I & ~fb_q;

  // Previous levels of the serial pins; they rest low between frames.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      sclk_q <= SER_CLK_I;
      le_q <= SER_LE_I;
    end
  end

  // Previous level of the feedback pulse, reset to its idle level.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fb_q <= 1'b0;
    end else begin
      fb_q <= FB_PULSE_I;
    end
  end

  // Shift register takes data most significant bit first.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      shift_q <= synth_cfg_pkg::WORD_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], SER_DATA_I};
    end
  end

  // Phase word and denominator; writes are accepted even in sleep.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_q <= synth_cfg_pkg::WORD_RESET;
    end else if (wr_phase) begin
      phase_q <= shift_q;
    end
  end

  // Control word.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_q <= synth_cfg_pkg::WORD_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= shift_q;
    end
  end

  // Boost and clock divider word.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      boost_q <= synth_cfg_pkg::WORD_RESET;
    end else if (wr_boost) begin
      boost_q <= shift_q;
    end
  end

  // Pending divider select, taken from every output stage write.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_pending_q <= 3'h0;
    end else if (wr_out) begin
      div_pending_q <= out_word.out_div_select;
    end
  end

  // Active divider select: direct, or copied at the integer/fraction write.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      OUT_DIV_SEL_O <= 3'h0;
    end else if (wr_out && !ctrl_q.double_buffer) begin
      OUT_DIV_SEL_O <= out_word.out_div_select;
    end else if (wr_int_frac && ctrl_q.double_buffer) begin
      OUT_DIV_SEL_O <= div_pending_q;
    end
  end

  // Reference edge selection, divider counter and halver.
  ref_path #(
    .RATIO_W(10)
  ) u_ref_path (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .ref_i(REF_CLK_I),
    .doubler_i(ctrl_q.ref_doubler),
    .halver_i(ctrl_q.reference_halver),
    .hold_i(hold),
    .ratio_i(ctrl_q.ref_ratio),
    .pfd_ref_o(pfd_ref)
  );

  // Lock detector, cleared while asleep.
  lock_detect #(
    .AGE_W(AGE_W),
    .CNT_W(CNT_W)
  ) u_lock_detect (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .clear_i(ctrl_q.software_sleep),
    .ref_evt_i(pfd_ref),
    .fb_evt_i(fb_evt),
    .win_i(win),
    .need_i(need),
    .lock_o(lock)
  );

  // Resync timeout counts comparison cycles after a frequency write.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      resync_cnt_q <= 12'h000;
      resync_armed_q <= 1'b0;
      RESYNC_FIRE_O <= 1'b0;
    end else begin
      RESYNC_FIRE_O <= 1'b0;
      if (boost_q.clkdiv_mode != synth_cfg_pkg::CLKDIV_RESYNC || hold) begin
        resync_armed_q <= 1'b0;
      end else if (wr_int_frac) begin
        resync_cnt_q <= boost_q.clkdiv_value;
        resync_armed_q <= 1'b1;
      end else if (resync_armed_q && pfd_ref) begin
        if (resync_cnt_q == 12'h000) begin
          resync_armed_q <= 1'b0;
          RESYNC_FIRE_O <= 1'b1;
        end else begin
          resync_cnt_q <= resync_cnt_q - 12'h001;
        end
      end
    end
  end

  // Multiplexer source selection.
  always_comb begin
    case (ctrl_q.internal_signal_select)
      synth_cfg_pkg::MUX_LOW: mux_d = 1'b0;
      synth_cfg_pkg::MUX_HIGH: mux_d = 1'b1;
      synth_cfg_pkg::MUX_REF_DIV: mux_d = pfd_ref;
      synth_cfg_pkg::MUX_FEEDBACK: mux_d = fb_evt;
      synth_cfg_pkg::MUX_LOCK: mux_d = lock;
      default: mux_d = 1'b0;
    endcase
  end

  // Reference event pulse toward the phase detector pin.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PFD_REF_O <= 1'b0;
    end else begin
      PFD_REF_O <= pfd_ref;
    end
  end

  // Digital lock detect pin.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LOCK_DETECT_O <= 1'b0;
    end else begin
      LOCK_DETECT_O <= lock;
    end
  end

  // Multiplexer pin, one cycle behind the selected signal.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MUX_OUT_O <= 1'b0;
    end else begin
      MUX_OUT_O <= mux_d;
    end
  end

  // Modulator dither is on only in low spur mode.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DITHER_EN_O <= 1'b0;
    end else begin
      DITHER_EN_O <= ctrl_q.noise_mode ==
                     synth_cfg_pkg::NOISE_LOW_SPUR;
    end
  end

  // Charge pump current, three-state and boost cell.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CP_CURRENT_O <= 3'h0;
      CP_TRISTATE_O <= 1'b0;
      BOOST_CELL_O <= 1'b0;
    end else begin
      CP_CURRENT_O <= ctrl_q.cp_current;
      CP_TRISTATE_O <= ctrl_q.cp_three_state |
                       ctrl_q.software_sleep;
      BOOST_CELL_O <= boost_q.boost_enable && !lock &&
                      !ctrl_q.software_sleep &&
                      !ctrl_q.cp_three_state;
    end
  end

  // Sleep state, output buffers and counter hold.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SLEEP_O <= 1'b0;
      OUT_BUF_EN_O <= 1'b0;
      COUNTER_HOLD_O <= 1'b0;
    end else begin
      SLEEP_O <= ctrl_q.software_sleep;
      OUT_BUF_EN_O <= !ctrl_q.software_sleep;
      COUNTER_HOLD_O <= hold;
    end
  end

  // Phase word and denominator as last written.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FRAC_DENOM_O <= 12'h000;
      PHASE_WORD_O <= 12'h000;
    end else begin
      FRAC_DENOM_O <= phase_q.fractional_denominator;
      PHASE_WORD_O <= phase_q.phase_word;
    end
  end

  // Resync enable follows the clock divider mode.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RESYNC_EN_O <= 1'b0;
    end else begin
      RESYNC_EN_O <= boost_q.clkdiv_mode ==
                     synth_cfg_pkg::CLKDIV_RESYNC;
    end
  end

endmodule
`default_nettype wire

// ---- tb/synth_cfg_properties.sv ----
// Checker of output relations of the serial config register block.
`timescale 1ns/1ps
`default_nettype none
module synth_cfg_checker (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic PFD_REF_O,
  input wire logic LOCK_DETECT_O,
  input wire logic CP_TRISTATE_O,
  input wire logic BOOST_CELL_O,
  input wire logic SLEEP_O,
  input wire logic OUT_BUF_EN_O,
  input wire logic COUNTER_HOLD_O,
  input wire logic RESYNC_EN_O,
  input wire logic RESYNC_FIRE_O
);
  // Each lock event is already counted at the rise; the bound is one below the short count.
  localparam int MIN_EVT = synth_cfg_pkg::LOCK_COUNT_SHORT - 1;
  logic [5:0] n_evt_q;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // Counts reference events since reset or the last sleep.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      n_evt_q <= 6'h00;
    end else if (SLEEP_O) begin
      n_evt_q <= 6'h00;
    end else if (PFD_REF_O && n_evt_q != 6'h3F) begin
      n_evt_q <= n_evt_q + 6'h01;
    end
  end
  property p_sleep_pump;
    SLEEP_O |-> CP_TRISTATE_O;
  endproperty
  a_sleep_pump: assert property (p_sleep_pump)
    else $error("pump driven in sleep");
  property p_sleep_buf;
    SLEEP_O |-> !OUT_BUF_EN_O;
  endproperty
  a_sleep_buf: assert property (p_sleep_buf)
    else $error("output buffers on in sleep");
  property p_sleep_lock;
    SLEEP_O ##1 SLEEP_O |-> !LOCK_DETECT_O;
  endproperty
  a_sleep_lock: assert property (p_sleep_lock)
    else $error("lock kept in sleep");
  property p_hold_pfd;
    COUNTER_HOLD_O [*4] |-> !PFD_REF_O;
  endproperty
  a_hold_pfd: assert property (p_hold_pfd)
    else $error("reference event while counters held");
  property p_pfd_pulse;
    PFD_REF_O |=> !PFD_REF_O;
  endproperty
  a_pfd_pulse: assert property (p_pfd_pulse)
    else $error("reference event longer than one cycle");
  property p_boost_lock;
    LOCK_DETECT_O ##1 LOCK_DETECT_O |-> !BOOST_CELL_O;
  endproperty
  a_boost_lock: assert property (p_boost_lock)
    else $error("boost cell on while locked");
  property p_fire;
    RESYNC_FIRE_O |-> RESYNC_EN_O ##1 !RESYNC_FIRE_O;
  endproperty
  a_fire: assert property (p_fire)
    else $error("bad resync pulse");
  property p_lock_cnt;
    $rose(LOCK_DETECT_O) |-> n_evt_q >= MIN_EVT;
  endproperty
  a_lock_cnt: assert property (p_lock_cnt)
    else $error("lock raised too early");
endmodule
bind synth_config_registers synth_cfg_checker i_chk (
  .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .PFD_REF_O(PFD_REF_O),
  .LOCK_DETECT_O(LOCK_DETECT_O), .CP_TRISTATE_O(CP_TRISTATE_O),
  .BOOST_CELL_O(BOOST_CELL_O), .SLEEP_O(SLEEP_O),
  .OUT_BUF_EN_O(OUT_BUF_EN_O), .COUNTER_HOLD_O(COUNTER_HOLD_O),
  .RESYNC_EN_O(RESYNC_EN_O), .RESYNC_FIRE_O(RESYNC_FIRE_O)
);
`default_nettype wire

// ---- tb/host_model.sv ----
// Host model that loads words over the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_le_o
);
  // Serial clock and strobe rest low between frames.
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_le_o = 1'b0;
  end
  // Shifts a word out MSB first, then pulses the load strobe.
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_i);
      ser_data_o <= w[i];
      ser_clk_o <= 1'b0;
      @(posedge clk_i);
      ser_clk_o <= 1'b1;
    end
    @(posedge clk_i);
    ser_clk_o <= 1'b0;
    ser_data_o <= ~w[0];
    ser_le_o <= 1'b1;
    @(posedge clk_i);
    ser_le_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial configuration register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Rows: doubler, halver, ratio, expected events per 12 toggles.
  localparam logic [15:0] TAB [4] = '{{2'h0, 10'h003, 4'h2},
    {2'h2, 10'h003, 4'h4}, {2'h3, 10'h003, 4'h2}, {2'h0, 10'h001, 4'h6}};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ref_clk = 1'b0;
  logic loop_on = 1'b0;
  logic fb, s_clk, s_dat, s_le, pfd, lock, mux, dith, tri_o, boost;
  logic slp, buf_en, hold, rs_en, fire;
  logic [2:0] cp, div;
  logic [11:0] den, ph;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_pfd = 0;
  int n_fire = 0;
  int n_mux = 0;
  synth_cfg_pkg::control_word_t cw;
  synth_cfg_pkg::boost_word_t bw;
  synth_cfg_pkg::phase_word_t pw;
  synth_cfg_pkg::out_stage_word_t ow;
  // Ideal loop: the feedback edge lines up with each reference event.
  assign fb = loop_on & pfd;
  // Free-running system clock.
  always #12.5 mclk = ~mclk;
  // Counts event pulses seen at the outputs.
  always @(posedge mclk) begin
    if (pfd === 1'b1) n_pfd++;
    if (fire === 1'b1) n_fire++;
    if (mux === 1'b1) n_mux++;
  end
  host_model i_host (.clk_i(mclk), .ser_clk_o(s_clk),
    .ser_data_o(s_dat), .ser_le_o(s_le));
  synth_config_registers i_dut (.MCLK_I(mclk), .ARST_N_I(arst_n),
    .SER_CLK_I(s_clk), .SER_DATA_I(s_dat), .SER_LE_I(s_le),
    .REF_CLK_I(ref_clk), .FB_PULSE_I(fb), .PFD_REF_O(pfd),
    .LOCK_DETECT_O(lock), .MUX_OUT_O(mux), .DITHER_EN_O(dith),
    .CP_CURRENT_O(cp), .CP_TRISTATE_O(tri_o), .BOOST_CELL_O(boost),
    .SLEEP_O(slp), .OUT_BUF_EN_O(buf_en), .COUNTER_HOLD_O(hold),
    .FRAC_DENOM_O(den), .PHASE_WORD_O(ph), .OUT_DIV_SEL_O(div),
    .RESYNC_EN_O(rs_en), .RESYNC_FIRE_O(fire));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Toggles the reference n times, four cycles per level.
  task automatic ref_run(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      ref_clk <= ~ref_clk;
    end
    repeat (5) @(posedge mclk);
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end
  // Main sequence of register loads and checks.
  initial begin
    cw = '0;
    bw = '0;
    pw = '0;
    ow = '0;
    cw.register_select_code = synth_cfg_pkg::SEL_CONTROL;
    bw.register_select_code = synth_cfg_pkg::SEL_BOOST_CLKDIV;
    pw.register_select_code = synth_cfg_pkg::SEL_PHASE_DENOM;
    ow.register_select_code = synth_cfg_pkg::SEL_OUT_STAGE;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({buf_en, slp, cp, div}, 32'h80);
    pw.phase_word = 12'h001;
    pw.fractional_denominator = 12'hABC;
    i_host.send(pw);
    chk({ph, den}, 32'h1ABC);
    pw.register_select_code = 3'h5;
    pw.phase_word = 12'h7FF;
    i_host.send(pw);
    chk(ph, 32'h1);
    pw.register_select_code = synth_cfg_pkg::SEL_PHASE_DENOM;
    for (int m = 0; m < 4; m++) begin
      cw.noise_mode = m[1:0];
      cw.cp_current = m[2:0] + 3'h4;
      cw.internal_signal_select = {2'h0, m[0]};
      i_host.send(cw);
      chk(dith, m[1:0] == synth_cfg_pkg::NOISE_LOW_SPUR);
      chk({mux, cp}, {m[0], m[2:0] + 3'h4});
    end
    ow.out_div_select = 3'h5;
    i_host.send(ow);
    chk(div, 32'h5);
    cw.double_buffer = 1'b1;
    i_host.send(cw);
    ow.out_div_select = 3'h2;
    i_host.send(ow);
    chk(div, 32'h5);
    i_host.send({29'h0, synth_cfg_pkg::SEL_INT_FRAC});
    chk(div, 32'h2);
    cw.cp_three_state = 1'b1;
    i_host.send(cw);
    chk({tri_o, boost}, 32'h2);
    cw.cp_three_state = 1'b0;
    for (int r = 0; r < 4; r++) begin
      cw.counter_reset = 1'b1;
      {cw.ref_doubler, cw.reference_halver} = TAB[r][15:14];
      cw.ref_ratio = TAB[r][13:4];
      i_host.send(cw);
      chk(hold, 32'h1);
      cw.counter_reset = 1'b0;
      i_host.send(cw);
      n_pfd = 0;
      ref_run(12);
      chk(n_pfd, TAB[r][3:0]);
    end
    bw.boost_enable = 1'b1;
    i_host.send(bw);
    cw.ref_doubler = 1'b1;
    cw.ref_ratio = 10'h001;
    cw.lock_cycle_count_select = 1'b1;
    cw.lock_window_select = 1'b1;
    cw.internal_signal_select = synth_cfg_pkg::MUX_LOCK;
    i_host.send(cw);
    chk(boost, 32'h1);
    loop_on <= 1'b1;
    ref_run(8);
    chk({lock, mux, boost}, 32'h6);
    cw.software_sleep = 1'b1;
    cw.lock_cycle_count_select = 1'b0;
    i_host.send(cw);
    chk({slp, buf_en, tri_o, hold, lock}, 32'h16);
    pw.phase_word = 12'h002;
    i_host.send(pw);
    chk({ph, den}, 32'h2ABC);
    cw.software_sleep = 1'b0;
    i_host.send(cw);
    ref_run(34);
    chk(lock, 32'h0);
    ref_run(10);
    chk(lock, 32'h1);
    bw.clkdiv_mode = synth_cfg_pkg::CLKDIV_RESYNC;
    bw.clkdiv_value = 12'h003;
    i_host.send(bw);
    chk(rs_en, 32'h1);
    cw.internal_signal_select = synth_cfg_pkg::MUX_REF_DIV;
    i_host.send(cw);
    i_host.send({29'h0, synth_cfg_pkg::SEL_INT_FRAC});
    n_fire = 0;
    n_mux = 0;
    n_pfd = 0;
    ref_run(12);
    chk(n_fire, 32'h1);
    chk(n_mux, 32'hC);
    chk(n_pfd, 32'hC);
    bw.clkdiv_mode = synth_cfg_pkg::CLKDIV_OFF;
    i_host.send(bw);
    chk(rs_en, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
